// file: src/gop_pkg.sv
// constants and register map for the genlock output offset and preset block
package gop_pkg;
  // register byte offsets
  localparam logic [7:0] REG_VOFF    = 8'h00;
  localparam logic [7:0] REG_HOFF    = 8'h04;
  localparam logic [7:0] REG_PHASE   = 8'h08;
  localparam logic [7:0] REG_POS     = 8'h0c;
  localparam logic [7:0] REG_SIZE    = 8'h10;
  localparam logic [7:0] REG_ASPECT  = 8'h14;
  localparam logic [7:0] REG_BORDER  = 8'h18;
  localparam logic [7:0] REG_SHARP   = 8'h1c;
  localparam logic [7:0] REG_CMD     = 8'h20;
  localparam logic [7:0] REG_PSTAT   = 8'h24;
  localparam logic [7:0] REG_REFLEN  = 8'h28;
  // field positions
  localparam int POS_X_LSB     = 0;
  localparam int POS_Y_LSB     = 16;
  localparam int CMD_SLOT_LSB  = 0;
  localparam int CMD_SAVE_BIT  = 4;
  localparam int CMD_RECALL_BIT = 5;
  localparam int PST_SAVED_LSB = 0;
  localparam int PST_VALID_BIT = 8;
  localparam int PST_SLOT_LSB  = 9;
  localparam int REF_LINE_LSB  = 0;
  localparam int REF_FRAME_LSB = 16;
  // field widths
  localparam int COORD_W  = 12;
  localparam int ASPECT_W = 2;
  localparam int LEVEL_W  = 8;
  localparam int SLOT_W   = 3;
  localparam int NSLOT    = 8;
  localparam int VOFF_W   = 11;
  localparam int HOFF_W   = 12;
  localparam int PHASE_W  = 7;
  // permitted ranges
  localparam int VOFF_MIN  = -1000;
  localparam int VOFF_MAX  = 1000;
  localparam int HOFF_MIN  = -2000;
  localparam int HOFF_MAX  = 2000;
  localparam int PHASE_MIN = -35;
  localparam int PHASE_MAX = 35;
  // reset values
  localparam logic [VOFF_W-1:0]   VOFF_RST   = 11'h000;
  localparam logic [HOFF_W-1:0]   HOFF_RST   = 12'h000;
  localparam logic [PHASE_W-1:0]  PHASE_RST  = 7'h00;
  localparam logic [COORD_W-1:0]  COORD_RST  = 12'h000;
  localparam logic [ASPECT_W-1:0] ASPECT_RST = 2'h0;
  localparam logic [LEVEL_W-1:0]  LEVEL_RST  = 8'h00;
endpackage : gop_pkg

// file: src/gop_genlock_offset.sv
// genlock output timing offsets, fine phase trim and selection presets
//
// What this block does
// - zero offsets give output aligned to reference
// - same offsets on serial and composite outputs
// - vertical offset in lines, -1000 to 1000
// - negative vertical offset makes output lead reference
// - horizontal offset in clocks, -2000 to 2000
// - composite phase trim -35 to 35 ns
// - eight slots hold all five selection settings
// - recall replaces all five settings at once
// - save copies settings and marks slot saved
// - last saved or recalled slot is active
`timescale 1ns/100ps
`default_nettype none
module gop_genlock_offset
  import gop_pkg::*;
#(
  parameter int H_W = 13,  // reference line length counter width
  parameter int V_W = 12   // reference frame length counter width
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                ref_hsync,          // reference line sync, pin
  input  wire logic                ref_vsync,          // reference frame sync, pin
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     sdi_line_start,
  output logic                     sdi_frame_start,
  output logic                     cvbs_line_start,
  output logic                     cvbs_frame_start,
  output logic signed [PHASE_W-1:0] cvbs_phase_ns,
  output logic      [COORD_W-1:0]  sel_pos_x,
  output logic      [COORD_W-1:0]  sel_pos_y,
  output logic      [COORD_W-1:0]  sel_width,
  output logic      [COORD_W-1:0]  sel_height,
  output logic      [ASPECT_W-1:0] sel_aspect,
  output logic      [LEVEL_W-1:0]  sel_border,
  output logic      [LEVEL_W-1:0]  sel_sharp,
  output logic      [NSLOT-1:0]    preset_saved,
  output logic                     preset_active_valid,
  output logic      [SLOT_W-1:0]   preset_active_slot
);

  // merge write data into an old word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // clamp a signed word into a range
  function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v, input int lo, input int hi);
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp_s

  // ---------------- bus slave ----------------
  logic                     wr_go;            // write takes effect this edge
  logic                     rd_go;            // read data sampled this cycle
  logic signed [VOFF_W-1:0]  voff;            // vertical offset, lines
  logic signed [HOFF_W-1:0]  hoff;            // horizontal offset, clocks
  logic [31:0]              next_readdata;    // read mux
  logic [31:0]              old_word;         // current word at address
  logic [31:0]              wr_word;          // merged write word
  logic [SLOT_W-1:0]        cmd_slot;         // slot named by a command
  logic                     cmd_save;         // save strobe
  logic                     cmd_recall;       // recall strobe

  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && avs_waitrequest;

  // one wait cycle then a single ready cycle per request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // reference measurement, declared early for the read mux
  logic [H_W-1:0] line_len;     // clocks per reference line
  logic [V_W-1:0] frame_len;    // lines per reference frame

  // read mux; unmapped addresses read zero
  always_comb begin
    old_word = 32'h0000_0000;
    unique case (avs_address)
      REG_VOFF:   old_word = 32'(signed'(voff));
      REG_HOFF:   old_word = 32'(signed'(hoff));
      REG_PHASE:  old_word = 32'(signed'(cvbs_phase_ns));
      REG_POS:    old_word = (32'(sel_pos_y) << POS_Y_LSB) | (32'(sel_pos_x) << POS_X_LSB);
      REG_SIZE:   old_word = (32'(sel_height) << POS_Y_LSB) | (32'(sel_width) << POS_X_LSB);
      REG_ASPECT: old_word = 32'(sel_aspect);
      REG_BORDER: old_word = 32'(sel_border);
      REG_SHARP:  old_word = 32'(sel_sharp);
      REG_PSTAT:  old_word = (32'(preset_active_slot) << PST_SLOT_LSB) |
                             (32'(preset_active_valid) << PST_VALID_BIT) |
                             (32'(preset_saved) << PST_SAVED_LSB);
      REG_REFLEN: old_word = (32'(frame_len) << REF_FRAME_LSB) | (32'(line_len) << REF_LINE_LSB);
      default:    old_word = 32'h0000_0000;  // command reads zero too
    endcase
    next_readdata = old_word;
    wr_word = be_merge(old_word, avs_writedata, avs_byteenable);
  end

  // read data registered in the wait cycle, stands in the ready cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= next_readdata;
    end
  end

  // command decode, pulses only on the accepting edge
  assign cmd_slot   = wr_word[CMD_SLOT_LSB +: SLOT_W];
  assign cmd_save   = wr_go && (avs_address == REG_CMD) && wr_word[CMD_SAVE_BIT];
  assign cmd_recall = wr_go && (avs_address == REG_CMD) && wr_word[CMD_RECALL_BIT] && !wr_word[CMD_SAVE_BIT];

  // timing offsets, clamped on write, zero after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      voff          <= VOFF_RST;
      hoff          <= HOFF_RST;
      cvbs_phase_ns <= PHASE_RST;
    end else if (wr_go) begin
      if (avs_address == REG_VOFF) begin
        voff <= VOFF_W'(clamp_s(wr_word, VOFF_MIN, VOFF_MAX));
      end
      if (avs_address == REG_HOFF) begin
        hoff <= HOFF_W'(clamp_s(wr_word, HOFF_MIN, HOFF_MAX));
      end
      if (avs_address == REG_PHASE) begin
        cvbs_phase_ns <= PHASE_W'(clamp_s(wr_word, PHASE_MIN, PHASE_MAX));
      end
    end
  end

  // ---------------- presets ----------------
  logic [COORD_W-1:0]  slot_x [NSLOT];   // stored position x
  logic [COORD_W-1:0]  slot_y [NSLOT];   // stored position y
  logic [COORD_W-1:0]  slot_w [NSLOT];   // stored width
  logic [COORD_W-1:0]  slot_h [NSLOT];   // stored height
  logic [ASPECT_W-1:0] slot_a [NSLOT];   // stored aspect
  logic [LEVEL_W-1:0]  slot_b [NSLOT];   // stored border
  logic [LEVEL_W-1:0]  slot_s [NSLOT];   // stored sharpness

  // slot store; data needs no reset, the saved mask guards it
  always_ff @(posedge clk) begin
    if (cmd_save) begin
      slot_x[cmd_slot] <= sel_pos_x;
      slot_y[cmd_slot] <= sel_pos_y;
      slot_w[cmd_slot] <= sel_width;
      slot_h[cmd_slot] <= sel_height;
      slot_a[cmd_slot] <= sel_aspect;
      slot_b[cmd_slot] <= sel_border;
      slot_s[cmd_slot] <= sel_sharp;
    end
  end

  // active selection: direct writes or a whole-slot recall in one edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_pos_x  <= COORD_RST;
      sel_pos_y  <= COORD_RST;
      sel_width  <= COORD_RST;
      sel_height <= COORD_RST;
      sel_aspect <= ASPECT_RST;
      sel_border <= LEVEL_RST;
      sel_sharp  <= LEVEL_RST;
    end else if (cmd_recall) begin
      // recall of a never-saved slot still loads, software checks the mask
      sel_pos_x  <= slot_x[cmd_slot];
      sel_pos_y  <= slot_y[cmd_slot];
      sel_width  <= slot_w[cmd_slot];
      sel_height <= slot_h[cmd_slot];
      sel_aspect <= slot_a[cmd_slot];
      sel_border <= slot_b[cmd_slot];
      sel_sharp  <= slot_s[cmd_slot];
    end else if (wr_go) begin
      unique case (avs_address)
        REG_POS: begin
          sel_pos_x <= wr_word[POS_X_LSB +: COORD_W];
          sel_pos_y <= wr_word[POS_Y_LSB +: COORD_W];
        end
        REG_SIZE: begin
          sel_width  <= wr_word[POS_X_LSB +: COORD_W];
          sel_height <= wr_word[POS_Y_LSB +: COORD_W];
        end
        REG_ASPECT: sel_aspect <= wr_word[ASPECT_W-1:0];
        REG_BORDER: sel_border <= wr_word[LEVEL_W-1:0];
        REG_SHARP:  sel_sharp  <= wr_word[LEVEL_W-1:0];
        default: ;  // other words hold no selection state
      endcase
    end
  end

  // saved mask and active flag; save wins over recall in one word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preset_saved        <= '0;
      preset_active_valid <= 1'b0;
      preset_active_slot  <= '0;
    end else begin
      if (cmd_save) begin
        preset_saved[cmd_slot] <= 1'b1;
      end
      if (cmd_save || cmd_recall) begin
        preset_active_valid <= 1'b1;
        preset_active_slot  <= cmd_slot;
      end
    end
  end

  // ---------------- reference timing ----------------
  logic [1:0]     hs_sync;    // line sync synchroniser
  logic [1:0]     vs_sync;    // frame sync synchroniser
  logic           hs_last;    // previous synchronised line sync
  logic           vs_last;    // previous synchronised frame sync
  logic           vs_seen;    // frame edge pending for next line edge
  logic [H_W-1:0] h_cnt;      // clocks since reference line edge
  logic [V_W-1:0] v_cnt;      // lines since reference frame edge
  logic           hs_rise;    // reference line edge
  logic [H_W-1:0] tgt_h;      // output line start position
  logic [V_W-1:0] tgt_v;      // output frame start line
  logic [V_W-1:0] tgt_v_eff;  // frame start line after horizontal wrap
  logic           hit_line;   // output line start due
  logic           hit_frame;  // output frame start due

  // two-stage synchronisers, first stage read only by second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_sync <= 2'h0;
      vs_sync <= 2'h0;
      hs_last <= 1'b0;
      vs_last <= 1'b0;
    end else begin
      hs_sync <= {hs_sync[0], ref_hsync};
      vs_sync <= {vs_sync[0], ref_vsync};
      hs_last <= hs_sync[1];
      vs_last <= vs_sync[1];
    end
  end

  assign hs_rise = hs_sync[1] && !hs_last;

  // line and frame counters locked to reference edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      h_cnt     <= '0;
      v_cnt     <= '0;
      vs_seen   <= 1'b0;
      line_len  <= '0;
      frame_len <= '0;
    end else begin
      if (vs_sync[1] && !vs_last) begin
        vs_seen <= 1'b1;
      end
      if (hs_rise) begin
        h_cnt    <= '0;
        line_len <= h_cnt + H_W'(1);
        if (vs_seen || (vs_sync[1] && !vs_last)) begin
          // frame edge counted from the next line edge
          v_cnt     <= '0;
          frame_len <= v_cnt + V_W'(1);
          vs_seen   <= 1'b0;
        end else begin
          v_cnt <= v_cnt + V_W'(1);
        end
      end else begin
        h_cnt <= h_cnt + H_W'(1);
      end
    end
  end

  // targets: positive delays, negative wraps back one line or frame
  always_comb begin
    tgt_h = H_W'(hoff);
    if (hoff < 0) begin
      tgt_h = line_len + H_W'(hoff);
    end
    tgt_v = V_W'(voff);
    if (voff < 0) begin
      tgt_v = frame_len + V_W'(voff);
    end
    tgt_v_eff = tgt_v;
    if (hoff < 0) begin
      tgt_v_eff = (tgt_v == '0) ? frame_len - V_W'(1) : tgt_v - V_W'(1);
    end
    hit_line  = (line_len != '0) && (h_cnt == tgt_h);
    hit_frame = hit_line && (frame_len != '0) && (v_cnt == tgt_v_eff);
  end

  // both outputs driven from the same decode, so they never drift apart
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdi_line_start   <= 1'b0;
      sdi_frame_start  <= 1'b0;
      cvbs_line_start  <= 1'b0;
      cvbs_frame_start <= 1'b0;
    end else begin
      sdi_line_start   <= hit_line;
      sdi_frame_start  <= hit_frame;
      cvbs_line_start  <= hit_line;
      cvbs_frame_start <= hit_frame;
    end
  end

  // ---------------- checks ----------------
  AST_ALIGN_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    (voff == 0 && hoff == 0 && line_len != '0 && h_cnt == '0) |=> sdi_line_start)
    else $error("zero offsets not aligned");
  AST_SAME_OUT: assert property (@(posedge clk) disable iff (sys_rst)
    sdi_line_start == cvbs_line_start && sdi_frame_start == cvbs_frame_start)
    else $error("outputs differ");
  AST_VOFF_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
    voff >= VOFF_MIN && voff <= VOFF_MAX)
    else $error("vertical offset out of range");
  AST_LEAD: assert property (@(posedge clk) disable iff (sys_rst)
    (voff == -1 && hoff >= 0 && frame_len != '0) |-> tgt_v == frame_len - V_W'(1))
    else $error("minus one line not leading");
  AST_HOFF_POS: assert property (@(posedge clk) disable iff (sys_rst)
    (hoff > 0 && line_len != '0 && h_cnt == H_W'(hoff)) |=> sdi_line_start)
    else $error("horizontal offset misplaced");
  AST_PHASE: assert property (@(posedge clk) disable iff (sys_rst)
    cvbs_phase_ns >= PHASE_MIN && cvbs_phase_ns <= PHASE_MAX)
    else $error("phase out of range");
  AST_RECALL: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_recall |=> sel_aspect == $past(slot_a[cmd_slot]) && sel_width == $past(slot_w[cmd_slot]))
    else $error("recall incomplete");
  AST_SAVE: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_save |=> preset_saved[$past(cmd_slot)] && slot_b[$past(cmd_slot)] == $past(sel_border))
    else $error("save not stored");
  AST_ACTIVE: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd_save || cmd_recall) |=> preset_active_valid && preset_active_slot == $past(cmd_slot))
    else $error("active slot wrong");
  AST_RST_ZERO: assert property (@(posedge clk)
    sys_rst |=> voff == 0 && hoff == 0 && cvbs_phase_ns == 0)
    else $error("offsets not zero after reset");
  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("ready held too long");
  COV_SAVE: cover property (@(posedge clk) disable iff (sys_rst) cmd_save);
  COV_RECALL: cover property (@(posedge clk) disable iff (sys_rst) cmd_save ##[1:50] cmd_recall);
  COV_FRAME: cover property (@(posedge clk) disable iff (sys_rst) sdi_frame_start && voff < 0);

endmodule : gop_genlock_offset
`default_nettype wire

// file: verification/gop_ref_model.sv
// reference sync source standing in for the studio genlock feed
`timescale 1ns/100ps
`default_nettype none
module gop_ref_model #(
  parameter int LINE_LEN    = 64,  // clocks per reference line
  parameter int FRAME_LINES = 16   // lines per reference frame
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      ref_hsync,
  output logic      ref_vsync
);
  int hpos = 0;  // clock within the line
  int lpos = 0;  // line within the frame
  // free running raster, the feed never waits for the converter
  always @(posedge clk) begin
    if (sys_rst) begin
      hpos <= 0;
      lpos <= 0;
    end else if (hpos == LINE_LEN - 1) begin
      hpos <= 0;
      lpos <= (lpos == FRAME_LINES - 1) ? 0 : lpos + 1;
    end else begin
      hpos <= hpos + 1;
    end
  end
  // vsync straddles the first line edge so its capture is unambiguous
  always @(posedge clk) begin
    ref_hsync <= !sys_rst && hpos < 8;
    ref_vsync <= !sys_rst && ((lpos == FRAME_LINES - 1 && hpos >= LINE_LEN / 2) || (lpos == 0 && hpos < LINE_LEN / 2));
  end
endmodule : gop_ref_model
`default_nettype wire

// file: verification/gop_genlock_offset_tb.sv
// self-checking bench for the genlock offset and preset block
`timescale 1ns/100ps
`default_nettype none
module gop_genlock_offset_tb;
  import gop_pkg::*;
  localparam int L     = 64;     // reference line length in clocks
  localparam int F     = 16;     // reference frame length in lines
  localparam int ALIGN = 3;      // bench clock count within the line at an aligned pulse
  localparam int LIMIT = 60000;  // cycle ceiling, tests need under 15000
  logic                      clk, sys_rst, ref_hsync, ref_vsync;
  logic                      avs_read, avs_write, avs_waitrequest;
  logic [7:0]                avs_address;
  logic [31:0]               avs_writedata, avs_readdata;
  logic [3:0]                avs_byteenable;
  logic                      sdi_line_start, sdi_frame_start, cvbs_line_start, cvbs_frame_start;
  logic signed [PHASE_W-1:0] cvbs_phase_ns;
  logic [COORD_W-1:0]        sel_pos_x, sel_pos_y, sel_width, sel_height;
  logic [ASPECT_W-1:0]       sel_aspect;
  logic [LEVEL_W-1:0]        sel_border, sel_sharp;
  logic [NSLOT-1:0]          preset_saved;
  logic                      preset_active_valid;
  logic [SLOT_W-1:0]         preset_active_slot;
  logic [31:0]               rd;          // last read word
  logic                      hs_q = 1'b0; // delayed reference line sync
  int                        n_errors = 0, checks = 0, cyc = 0, hcnt = 0, lcnt = 0;

  gop_genlock_offset u_gop_genlock_offset (.clk, .sys_rst, .ref_hsync, .ref_vsync, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sdi_line_start,
    .sdi_frame_start, .cvbs_line_start, .cvbs_frame_start, .cvbs_phase_ns, .sel_pos_x, .sel_pos_y, .sel_width,
    .sel_height, .sel_aspect, .sel_border, .sel_sharp, .preset_saved, .preset_active_valid, .preset_active_slot);
  gop_ref_model #(.LINE_LEN(L), .FRAME_LINES(F)) u_gop_ref_model (.clk, .sys_rst, .ref_hsync, .ref_vsync);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // raster position seen by the bench, hang guard and output pairing
  always @(posedge clk) begin
    hs_q <= ref_hsync;
    hcnt <= (ref_hsync && !hs_q) ? 0 : hcnt + 1;
    if (ref_hsync && !hs_q) begin
      lcnt <= ref_vsync ? 0 : lcnt + 1;
    end
    cyc <= cyc + 1;
    if (sdi_line_start | cvbs_line_start) chk("line pulse pair", cvbs_line_start, sdi_line_start);
    if (sdi_frame_start | cvbs_frame_start) chk("frame pulse pair", cvbs_frame_start, sdi_frame_start);
    // hang guard last, so nothing runs after the verdict
    if (cyc == LIMIT) begin
      n_errors++;
      print_verdict();
    end
  end

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk("bus answer", n < 100, 1'b1);
    @(posedge clk);
  endtask : bus

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, rd, e);
  endtask : rdchk

  // wait k output pulses, line or frame, with a bound per pulse
  task automatic wait_pulse(input logic frame, input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((frame ? sdi_frame_start : sdi_line_start) !== 1'b1 && n < 3000);
      chk("pulse arrives", n < 3000, 1'b1);
    end
  endtask : wait_pulse

  task automatic set_sel(input logic [31:0] p, input logic [31:0] s, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] sh);
    bus(1'b1, REG_POS, p);
    bus(1'b1, REG_SIZE, s);
    bus(1'b1, REG_ASPECT, a);
    bus(1'b1, REG_BORDER, b);
    bus(1'b1, REG_SHARP, sh);
  endtask : set_sel

  // all seven selection outputs at once
  task automatic sel_chk(input logic [65:0] e);
    chk("sel position", {sel_pos_x, sel_pos_y}, 32'(e[65:42]));
    chk("sel size", {sel_width, sel_height}, 32'(e[41:18]));
    chk("sel look", {sel_aspect, sel_border, sel_sharp}, 32'(e[17:0]));
  endtask : sel_chk

  task automatic t_reset();
    rdchk("vert offset reset", REG_VOFF, 32'h0);
    rdchk("hor offset reset", REG_HOFF, 32'h0);
    rdchk("phase reset", REG_PHASE, 32'h0);
    rdchk("preset status reset", REG_PSTAT, 32'h0);
    sel_chk(66'h0);
  endtask : t_reset

  // out of range values pin to the nearest limit, endpoints stay
  task automatic t_clamp();
    logic [7:0] ca [8] = '{REG_VOFF, REG_VOFF, REG_HOFF, REG_HOFF, REG_PHASE, REG_PHASE, REG_PHASE, REG_HOFF};
    int         cw [8] = '{1500, -1001, 2000, -3000, 36, -35, 32'h7fffffff, 32'h80000000};
    int         ce [8] = '{1000, -1000, 2000, -2000, 35, -35, 35, -2000};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, ca[i], cw[i]);
      rdchk("offset clamp", ca[i], ce[i]);
      if (ca[i] == REG_PHASE) chk("phase output", 32'(cvbs_phase_ns), ce[i]);
    end
    bus(1'b1, REG_HOFF, 32'h0);
    bus(1'b1, REG_PHASE, 32'h0);
    bus(1'b1, REG_VOFF, 32'h0);
  endtask : t_clamp

  task automatic t_presets();
    set_sel(32'h0123_0456, 32'h0789_0abc, 32'h2, 32'h5a, 32'hc3);
    bus(1'b1, REG_CMD, 32'h10);
    rdchk("status after save 0", REG_PSTAT, 32'h0000_0101);
    set_sel(32'h0fff_0001, 32'h0002_0ffe, 32'h1, 32'h01, 32'hff);
    bus(1'b1, REG_CMD, 32'h17);
    rdchk("status after save 7", REG_PSTAT, 32'h0000_0f81);
    bus(1'b1, REG_CMD, 32'h20);
    sel_chk({12'h456, 12'h123, 12'habc, 12'h789, 2'h2, 8'h5a, 8'hc3});
    rdchk("status after recall 0", REG_PSTAT, 32'h0000_0181);
    bus(1'b1, REG_CMD, 32'h27);
    sel_chk({12'h001, 12'hfff, 12'hffe, 12'h002, 2'h1, 8'h01, 8'hff});
    // save and recall together: save takes it, selection unchanged
    bus(1'b1, REG_CMD, 32'h33);
    chk("active preset port", {preset_active_valid, preset_active_slot, preset_saved}, 12'hb89);
    sel_chk({12'h001, 12'hfff, 12'hffe, 12'h002, 2'h1, 8'h01, 8'hff});
    // byte enables merge into the current word: only y changes
    avs_byteenable <= 4'hc;
    bus(1'b1, REG_POS, 32'h0555_0aaa);
    avs_byteenable <= 4'hf;
    rdchk("byte enable merge", REG_POS, 32'h0555_0001);
    rdchk("command reads zero", REG_CMD, 32'h0);
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    rdchk("unmapped reads zero", 8'h3c, 32'h0);
  endtask : t_presets

  task automatic t_reflen();
    repeat (3 * L * F) @(posedge clk);
    rdchk("reference lengths", REG_REFLEN, (F << 16) | L);
  endtask : t_reflen

  // line pulse position for boundary horizontal offsets
  task automatic t_hoff();
    int hv [4] = '{0, 60, -7, -63};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, REG_HOFF, hv[i]);
      wait_pulse(1'b0, 3);
      chk("line pulse phase", hcnt, ((ALIGN + hv[i]) % L + L) % L);
    end
    bus(1'b1, REG_HOFF, 32'h0);
  endtask : t_hoff

  // frame pulse line for vertical offsets, negative leads
  task automatic t_voff();
    int vv [4] = '{0, -1, 5, -15};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, REG_VOFF, vv[i]);
      wait_pulse(1'b1, 2);
      chk("frame pulse line", lcnt, (vv[i] % F + F) % F);
      chk("frame on line pulse", sdi_line_start, 1'b1);
    end
    // negative horizontal offset pulls the frame start into the line before
    bus(1'b1, REG_HOFF, -7);
    wait_pulse(1'b1, 2);
    chk("frame pulse early line", lcnt, ((vv[3] - 1) % F + F) % F);
    chk("frame pulse early clock", hcnt, ((ALIGN - 7) % L + L) % L);
    bus(1'b1, REG_HOFF, 32'h0);
  endtask : t_voff

  initial begin
    sys_rst        = 1'b1;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 8'h00;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    repeat (2) @(posedge clk);
    chk("wait during reset", avs_waitrequest, 1'b1);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_clamp();
    t_presets();
    t_reflen();
    t_hoff();
    t_voff();
    print_verdict();
  end
endmodule : gop_genlock_offset_tb
`default_nettype wire
